// File: hw/cdc_comparator_debounce_ctrl.sv
// Comparator and amplifier trim control block with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cdc_comparator_debounce_ctrl
  import cdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Analog comparator decisions, high when positive input exceeds negative
  input wire logic cmp_a_pos_above,
  input wire logic cmp_b_pos_above,
  // Comparator controls to the analog front end
  output logic cmp_a_on,
  output logic cmp_b_on,
  output logic [1:0] cmp_a_bias_sel,
  output logic [1:0] cmp_b_bias_sel,
  output logic cmp_a_invert,
  output logic cmp_b_invert,
  // Comparator results
  output logic cmp_a_raw_out,
  output logic cmp_b_raw_out,
  output logic cmp_a_filtered_out,
  output logic cmp_b_filtered_out,
  // Amplifier offset calibration controls
  output logic amp_cal_mode,
  output logic amp_cal_ref_sel,
  output logic [5:0] amp_trim_value
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic amp_mode_r;
  logic amp_ref_r;
  logic [CDC_AMP_TRIM_W-1:0] amp_trim_r;
  logic [1:0] cmp_on_r;
  logic [1:0] cmp_inv_r;
  logic [1:0] cmp_len_r [2];
  logic [1:0] cmp_bias_r [2];
  logic [1:0] cmp_raw_r;
  logic [1:0] cmp_filt;
  logic [1:0] cmp_in;

  assign cmp_in = {cmp_b_pos_above, cmp_a_pos_above};

  // ************************************************************
  // Bus slave state
  // ************************************************************
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic do_write;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;

  // Decode a word address to a mapped register; used by both read and write paths
  function automatic logic cdc_mapped(input logic [31:0] addr);
    logic [3:0] low;
    low = addr[3:0];
    cdc_mapped = (addr[31:4] == 28'h0000000) &&
                 (low == CDC_AMP_TRIM_OFS || low == CDC_CMP_A_CTRL_OFS ||
                  low == CDC_CMP_B_CTRL_OFS || low == CDC_CMP_POL_OFS);
  endfunction : cdc_mapped

  logic aw_addr_ok_r;

  // ************************************************************
  // Write address and data capture, in either order
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      aw_addr_ok_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr[3:0];
      aw_addr_ok_r <= cdc_mapped(s_axi_awaddr);
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Ready is registered so the outputs stay flip-flop driven
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_hit = do_write && aw_addr_ok_r && w_lane_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CDC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_addr_ok_r ? CDC_RESP_OKAY : CDC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Amplifier offset register
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_mode_r <= CDC_AMP_RESET[CDC_AMP_MODE_BIT];
      amp_ref_r <= CDC_AMP_RESET[CDC_AMP_REF_BIT];
      amp_trim_r <= CDC_AMP_RESET[CDC_AMP_TRIM_LSB +: CDC_AMP_TRIM_W];
    end else if (wr_hit && aw_addr_r == CDC_AMP_TRIM_OFS) begin
      amp_mode_r <= w_data_r[CDC_AMP_MODE_BIT];
      amp_ref_r <= w_data_r[CDC_AMP_REF_BIT];
      amp_trim_r <= w_data_r[CDC_AMP_TRIM_LSB +: CDC_AMP_TRIM_W];
    end
  end

  // ************************************************************
  // Polarity register
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_inv_r <= CDC_POL_RESET;
    end else if (wr_hit && aw_addr_r == CDC_CMP_POL_OFS) begin
      cmp_inv_r <= {w_data_r[CDC_POL_B_BIT], w_data_r[CDC_POL_A_BIT]};
    end
  end

  // ************************************************************
  // Per-comparator control, input sync, raw output and filter
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      localparam logic [3:0] CTRL_OFS = (gi == 0) ? CDC_CMP_A_CTRL_OFS : CDC_CMP_B_CTRL_OFS;
      logic [2:0] sync_r;
      logic stable_r;

      // Writable fields only; read-only and unimplemented bits are never stored
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cmp_on_r[gi] <= CDC_CMP_RESET[CDC_CMP_ON_BIT];
          cmp_len_r[gi] <= CDC_CMP_RESET[CDC_CMP_LEN_LSB +: 2];
          cmp_bias_r[gi] <= CDC_CMP_RESET[CDC_CMP_BIAS_LSB +: 2];
        end else if (wr_hit && aw_addr_r == CTRL_OFS) begin
          cmp_on_r[gi] <= w_data_r[CDC_CMP_ON_BIT];
          cmp_len_r[gi] <= w_data_r[CDC_CMP_LEN_LSB +: 2];
          cmp_bias_r[gi] <= w_data_r[CDC_CMP_BIAS_LSB +: 2];
        end
      end

      // Analog decision is asynchronous; a change counts once stages two and three agree
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync_r <= 3'h0;
          stable_r <= 1'b0;
        end else begin
          sync_r <= {sync_r[1:0], cmp_in[gi]};
          if (sync_r[1] == sync_r[2]) begin
            stable_r <= sync_r[2];
          end
        end
      end

      // Off comparator reads low before inversion, so it shows the polarity value
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cmp_raw_r[gi] <= 1'b0;
        end else begin
          cmp_raw_r[gi] <= (cmp_on_r[gi] & stable_r) ^ cmp_inv_r[gi];
        end
      end

      cdc_debounce u_debounce (
        .clk(clk),
        .rst(rst),
        .raw(cmp_raw_r[gi]),
        .len_sel(cmp_len_r[gi]),
        .filt(cmp_filt[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Read path
  // ************************************************************
  function automatic logic [7:0] cdc_ctrl_byte(input logic raw, input logic on, input logic filt,
                                               input logic [1:0] len, input logic [1:0] bias);
    cdc_ctrl_byte = {raw, on, filt, 1'b0, len, bias};
  endfunction : cdc_ctrl_byte

  always_comb begin
    rd_byte = 8'h00;
    case (s_axi_araddr[3:0])
      CDC_AMP_TRIM_OFS: rd_byte = {amp_mode_r, amp_ref_r, amp_trim_r};
      CDC_CMP_A_CTRL_OFS: rd_byte = cdc_ctrl_byte(cmp_raw_r[0], cmp_on_r[0], cmp_filt[0],
                                                  cmp_len_r[0], cmp_bias_r[0]);
      CDC_CMP_B_CTRL_OFS: rd_byte = cdc_ctrl_byte(cmp_raw_r[1], cmp_on_r[1], cmp_filt[1],
                                                  cmp_len_r[1], cmp_bias_r[1]);
      CDC_CMP_POL_OFS: rd_byte = {6'h00, cmp_inv_r};
      default: rd_byte = 8'h00;
    endcase
  end

  assign rd_hit = cdc_mapped(s_axi_araddr);

  // One read at a time; a new address is taken only once the last data is gone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp <= rd_hit ? CDC_RESP_OKAY : CDC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Output mirrors of internal flip-flops
  // ************************************************************
  assign cmp_a_on = cmp_on_r[0];
  assign cmp_b_on = cmp_on_r[1];
  assign cmp_a_bias_sel = cmp_bias_r[0];
  assign cmp_b_bias_sel = cmp_bias_r[1];
  assign cmp_a_invert = cmp_inv_r[0];
  assign cmp_b_invert = cmp_inv_r[1];
  assign cmp_a_raw_out = cmp_raw_r[0];
  assign cmp_b_raw_out = cmp_raw_r[1];
  assign cmp_a_filtered_out = cmp_filt[0];
  assign cmp_b_filtered_out = cmp_filt[1];
  assign amp_cal_mode = amp_mode_r;
  assign amp_cal_ref_sel = amp_ref_r;
  assign amp_trim_value = amp_trim_r;

endmodule : cdc_comparator_debounce_ctrl

// File: hw/cdc_debounce.sv
// Debounce filter for one comparator raw output
`timescale 1ns/1ps
module cdc_debounce
  import cdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filter
  input wire logic raw,
  input wire logic [1:0] len_sel,
  output logic filt
);

  // ************************************************************
  // Run-length counter
  // ************************************************************
  logic [CDC_CNT_W-1:0] run_r;
  logic [CDC_CNT_W-1:0] limit;

  assign limit = cdc_filter_len(len_sel);

  // Output changes only after current plus limit previous samples all differ from it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= '0;
      filt <= 1'b0;
    end else if (raw == filt) begin
      run_r <= '0;
    end else if (run_r >= limit) begin
      run_r <= '0;
      filt <= raw;
    end else begin
      run_r <= run_r + 7'h01;
    end
  end

endmodule : cdc_debounce

// File: hw/cdc_pkg.sv
// Package with register map, field layout, reset values and filter lengths for the comparator block
package cdc_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [3:0] CDC_AMP_TRIM_OFS = 4'h0;
  localparam logic [3:0] CDC_CMP_A_CTRL_OFS = 4'h4;
  localparam logic [3:0] CDC_CMP_B_CTRL_OFS = 4'h8;
  localparam logic [3:0] CDC_CMP_POL_OFS = 4'hc;

  // ************************************************************
  // Amplifier offset register fields
  // ************************************************************
  localparam int CDC_AMP_MODE_BIT = 7;
  localparam int CDC_AMP_REF_BIT = 6;
  localparam int CDC_AMP_TRIM_LSB = 0;
  localparam int CDC_AMP_TRIM_W = 6;
  localparam logic [7:0] CDC_AMP_RESET = 8'h20;

  // ************************************************************
  // Comparator control register fields
  // ************************************************************
  localparam int CDC_CMP_RAW_BIT = 7;
  localparam int CDC_CMP_ON_BIT = 6;
  localparam int CDC_CMP_FILT_BIT = 5;
  localparam int CDC_CMP_LEN_LSB = 2;
  localparam int CDC_CMP_BIAS_LSB = 0;
  localparam logic [7:0] CDC_CMP_RESET = 8'h00;

  // Polarity register: one invert bit per comparator
  localparam int CDC_POL_A_BIT = 0;
  localparam int CDC_POL_B_BIT = 1;
  localparam logic [1:0] CDC_POL_RESET = 2'h0;

  // ************************************************************
  // Filter lengths in system clocks (extra samples beyond current)
  // ************************************************************
  localparam int CDC_CNT_W = 7;
  localparam logic [CDC_CNT_W-1:0] CDC_LEN_NONE = 7'h00;
  localparam logic [CDC_CNT_W-1:0] CDC_LEN_SHORT = 7'h1f;
  localparam logic [CDC_CNT_W-1:0] CDC_LEN_MID = 7'h3f;
  localparam logic [CDC_CNT_W-1:0] CDC_LEN_LONG = 7'h7e;

  // AXI responses
  localparam logic [1:0] CDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CDC_RESP_SLVERR = 2'h2;

  // Filter length select to number of previous samples
  function automatic logic [CDC_CNT_W-1:0] cdc_filter_len(input logic [1:0] sel);
    case (sel)
      2'h1: cdc_filter_len = CDC_LEN_SHORT;
      2'h2: cdc_filter_len = CDC_LEN_MID;
      2'h3: cdc_filter_len = CDC_LEN_LONG;
      default: cdc_filter_len = CDC_LEN_NONE;
    endcase
  endfunction : cdc_filter_len

endpackage : cdc_pkg

// File: verification/cdc_ctrl_sva.sv
// Port checker for the comparator and amplifier register block
`timescale 1ns/1ps
module cdc_ctrl_sva
  import cdc_pkg::*;
(
  // Clock, reset and write response
  input logic clk,
  input logic rst,
  input logic s_axi_bvalid,
  // Comparators
  input logic cmp_a_pos_above, cmp_a_on, cmp_a_invert, cmp_a_raw_out, cmp_a_filtered_out,
  input logic cmp_b_pos_above, cmp_b_on, cmp_b_invert, cmp_b_raw_out, cmp_b_filtered_out,
  // Amplifier
  input logic amp_cal_mode,
  input logic amp_cal_ref_sel,
  input logic [5:0] amp_trim_value
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Six samples cover the three sync stages, the stable register and the raw register
  property p_raw_a;
    (cmp_a_on && $stable(cmp_a_pos_above) && $stable(cmp_a_invert)) [*6]
      |-> cmp_a_raw_out == (cmp_a_pos_above ^ cmp_a_invert);
  endproperty
  a_raw_a: assert property (p_raw_a) else $error("raw a wrong");
  property p_raw_b;
    (cmp_b_on && $stable(cmp_b_pos_above) && $stable(cmp_b_invert)) [*6]
      |-> cmp_b_raw_out == (cmp_b_pos_above ^ cmp_b_invert);
  endproperty
  a_raw_b: assert property (p_raw_b) else $error("raw b wrong");
  property p_off_a;
    (!cmp_a_on && $stable(cmp_a_invert)) [*6] |-> cmp_a_raw_out == cmp_a_invert;
  endproperty
  a_off_a: assert property (p_off_a) else $error("off a wrong");
  property p_off_b;
    (!cmp_b_on && $stable(cmp_b_invert)) [*6] |-> cmp_b_raw_out == cmp_b_invert;
  endproperty
  a_off_b: assert property (p_off_b) else $error("off b wrong");
  property p_filt_a;
    $changed(cmp_a_filtered_out) |-> cmp_a_filtered_out == $past(cmp_a_raw_out);
  endproperty
  a_filt_a: assert property (p_filt_a) else $error("filter a moved");
  property p_filt_b;
    $changed(cmp_b_filtered_out) |-> cmp_b_filtered_out == $past(cmp_b_raw_out);
  endproperty
  a_filt_b: assert property (p_filt_b) else $error("filter b moved");
  property p_amp_wr;
    !$stable({amp_cal_mode, amp_cal_ref_sel, amp_trim_value}) |-> $rose(s_axi_bvalid);
  endproperty
  a_amp_wr: assert property (p_amp_wr) else $error("amp field moved");
  property p_rst_val;
    $fell(rst) |-> !cmp_a_on && !cmp_b_on && !cmp_a_raw_out && !cmp_b_filtered_out;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset value");
  c_filt_a: cover property ($rose(cmp_a_filtered_out));
  c_filt_b: cover property ($fell(cmp_b_filtered_out));
  c_wr: cover property ($rose(s_axi_bvalid));
endmodule : cdc_ctrl_sva

bind cdc_comparator_debounce_ctrl cdc_ctrl_sva u_sva (
  .clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
  .cmp_a_pos_above(cmp_a_pos_above), .cmp_a_on(cmp_a_on), .cmp_a_invert(cmp_a_invert),
  .cmp_a_raw_out(cmp_a_raw_out), .cmp_a_filtered_out(cmp_a_filtered_out),
  .cmp_b_pos_above(cmp_b_pos_above), .cmp_b_on(cmp_b_on), .cmp_b_invert(cmp_b_invert),
  .cmp_b_raw_out(cmp_b_raw_out), .cmp_b_filtered_out(cmp_b_filtered_out),
  .amp_cal_mode(amp_cal_mode), .amp_cal_ref_sel(amp_cal_ref_sel), .amp_trim_value(amp_trim_value)
);

// File: verification/tb_comparator_debounce_ctrl.sv
// Self-checking bench for the comparator and amplifier register block
`timescale 1ns/1ps
module tb_comparator_debounce_ctrl;
  import cdc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] pos = 0;
  logic awready, wready, bvalid, arready, rvalid, amp_mode, amp_ref;
  logic [1:0] bresp, rresp, raw, filt, on, inv, bias_a, bias_b;
  logic [5:0] amp_trim;
  int errors = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  cdc_comparator_debounce_ctrl dut (
    .clk(clk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .cmp_a_pos_above(pos[0]), .cmp_b_pos_above(pos[1]), .cmp_a_on(on[0]), .cmp_b_on(on[1]),
    .cmp_a_bias_sel(bias_a), .cmp_b_bias_sel(bias_b), .cmp_a_invert(inv[0]), .cmp_b_invert(inv[1]),
    .cmp_a_raw_out(raw[0]), .cmp_b_raw_out(raw[1]), .cmp_a_filtered_out(filt[0]),
    .cmp_b_filtered_out(filt[1]), .amp_cal_mode(amp_mode), .amp_cal_ref_sel(amp_ref),
    .amp_trim_value(amp_trim)
  );
  // ********
  // Bus cycles and comparisons
  // ********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_cnt(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  task automatic wrchk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] t;
    t = 2'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    // Address and data may be taken at different edges
    do begin
      @(posedge clk);
      t = t | {awready, wready};
      if (t[1]) awvalid <= 0;
      if (t[0]) wvalid <= 0;
    end while (t != 2'h3);
    while (!bvalid) @(posedge clk);
    chk("bresp", 32'(e), 32'(bresp));
    bready <= 0;
  endtask : wrchk
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    chk("rdata", e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 0;
  endtask : rdchk
  function automatic int exp_n(input logic [1:0] s);
    case (s)
      2'h1: return 31;
      2'h2: return 63;
      2'h3: return 126;
      default: return 0;
    endcase
  endfunction : exp_n
  // Settle, send a pulse one sample too short, then a lasting change
  task automatic run(input int c, input logic p, input logic [1:0] s);
    int n;
    int k;
    n = exp_n(s);
    wrchk(32'hc, 32'(p) << c, CDC_RESP_OKAY);
    wrchk(c ? 32'h8 : 32'h4, 32'h40 | 32'(s) << 2 | 32'($urandom % 4), CDC_RESP_OKAY);
    chk("on", 32'h1, 32'(on[c]));
    pos[c] <= 0;
    repeat (150) @(posedge clk);
    if (n > 0) begin
      pos[c] <= 1;
      repeat (n) @(posedge clk);
      pos[c] <= 0;
      repeat (150) @(posedge clk);
    end
    chk("filt held", 32'(p), 32'(filt[c]));
    pos[c] <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (raw[c] !== !p && k < 20);
    chk("raw", 32'(!p), 32'(raw[c]));
    k = 0;
    while (filt[c] === p && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk_cnt("filter delay", n + 1, k);
  endtask : run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // ********
  // Tests
  // ********
  initial begin
    logic [31:0] d;
    void'($urandom(32'h8b0fad61));
    repeat (4) @(posedge clk);
    rst <= 0;
    rdchk(32'h0, {24'h0, CDC_AMP_RESET}, CDC_RESP_OKAY);
    rdchk(32'h4, 32'h0, CDC_RESP_OKAY);
    rdchk(32'h8, 32'h0, CDC_RESP_OKAY);
    rdchk(32'h10, 32'h0, CDC_RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : $urandom;
      wrchk(32'h0, d, CDC_RESP_OKAY);
      rdchk(32'h0, d & 32'hff, CDC_RESP_OKAY);
      chk("amp mode", 32'(d[7]), 32'(amp_mode));
      chk("amp ref", 32'(d[6]), 32'(amp_ref));
      chk("amp trim", 32'(d[5:0]), 32'(amp_trim));
    end
    wrchk(32'h14, 32'hff, CDC_RESP_SLVERR);
    // Low byte lane disabled: the write is answered but must leave the register alone
    wstrb <= 4'he;
    wrchk(32'h0, ~d, CDC_RESP_OKAY);
    wstrb <= 4'hf;
    rdchk(32'h0, d & 32'hff, CDC_RESP_OKAY);
    $display("test amplifier done");
    for (int c = 0; c < 2; c++) begin
      d = ($urandom | 32'hb0) & 32'hbf;
      wrchk(c ? 32'h8 : 32'h4, d, CDC_RESP_OKAY);
      rdchk(c ? 32'h8 : 32'h4, d & 32'hf, CDC_RESP_OKAY);
      chk("bias", 32'(d[1:0]), 32'(c ? bias_b : bias_a));
      chk("on", 32'h0, 32'(on[c]));
      pos <= 2'($urandom);
      wrchk(32'hc, 32'h1 << c, CDC_RESP_OKAY);
      repeat (140) @(posedge clk);
      rdchk(c ? 32'h8 : 32'h4, d & 32'hf | 32'ha0, CDC_RESP_OKAY);
      chk("invert", 32'h1 << c, 32'(inv));
      rdchk(32'hc, 32'h1 << c, CDC_RESP_OKAY);
      wrchk(32'hc, 32'h0, CDC_RESP_OKAY);
    end
    $display("test control done");
    for (int c = 0; c < 2; c++)
      for (int p = 0; p < 2; p++)
        for (int s = 0; s < 4; s++)
          run(c, p[0], s[1:0]);
    $display("test filter done");
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule : tb_comparator_debounce_ctrl
